// ### logic/acr_channel_regs.sv
// Channel-two configuration register bank behind a two-wire control port
//
// Contract
// - Input setup bit 7 picks microphone (0) or line-level (1) input.
// - Source bits 6:5 pick differential, single-ended or pulse-density mic; 3 reserved.
// - Bit 4 picks AC or DC coupling, ignored for pulse-density mic input.
// - Impedance bits 3:2 pick 2.5, 10 or 20 kilohm; code 3 reserved.
// - Input setup bit 1 is reserved, reads zero, software writes only zero.
// - Bit 0 enables the dynamic processing chosen by the shared select register.
// - Channel gain code in bits 7:1 gives half-decibel steps, 0 to 42 dB; codes above 84 decode unclamped, up to 63.5 dB.
// - Polarity bit makes gain negative down to -11 dB; high impedance only, though decode applies it at any impedance.
// - Digital volume code zero mutes the channel output completely.
// - Volume codes 1 to 255 span -100 to 27 dB, unity at 201.
// - Trim code in bits 7:4 spans -0.8 to 0.7 dB in tenth steps.
// - Trim register low nibble is reserved, reads zero, written only zero.
// - Digital volume resets to 0xC9, unity gain.
`timescale 1ns/1ps
module acr_channel_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output acr_pkg::acr_cfg_s cfg
);

    acr_pkg::acr_ctl_s s_r;
    acr_pkg::acr_ctl_s s_nxt;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] byte_in;
    logic [7:0] rd_data;

    // Pins are synchronous already; one previous sample is enough for edges
    assign scl_rise = scl_in & ~s_r.scl_prev;
    assign scl_fall = ~scl_in & s_r.scl_prev;
    assign start_seen = scl_in & s_r.scl_prev & s_r.sda_prev & ~sda_in;
    assign stop_seen = scl_in & s_r.scl_prev & ~s_r.sda_prev & sda_in;
    assign byte_in = {s_r.shreg[6:0], sda_in};

    // Read-back mux; reserved bits are never stored, so they read zero
    always_comb begin
        case (s_r.ptr)
            acr_pkg::OFS_INPUT_SETUP: begin
                rd_data = s_r.regs.input_setup;
            end
            acr_pkg::OFS_GAIN_SETTING: begin
                rd_data = s_r.regs.gain_setting;
            end
            acr_pkg::OFS_VOLUME_SETTING: begin
                rd_data = s_r.regs.volume_setting;
            end
            acr_pkg::OFS_GAIN_TRIM: begin
                rd_data = s_r.regs.gain_trim;
            end
            default: begin
                rd_data = 8'h00;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.sda_o = 1'b0;
        s_nxt.scl_prev = scl_in;
        s_nxt.sda_prev = sda_in;
        if (start_seen) begin
            // Also serves as repeated start; the pointer survives it
            s_nxt.st = acr_pkg::ST_ADDR;
            s_nxt.bitcnt = 3'h0;
            s_nxt.sda_oe = 1'b0;
            s_nxt.ack_on = 1'b0;
        end else if (stop_seen) begin
            s_nxt.st = acr_pkg::ST_IDLE;
            s_nxt.sda_oe = 1'b0;
            s_nxt.ack_on = 1'b0;
        end else begin
            case (s_r.st)
                acr_pkg::ST_IDLE: begin
                    s_nxt.sda_oe = 1'b0;
                end
                acr_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        s_nxt.shreg = byte_in;
                        s_nxt.bitcnt = s_r.bitcnt + 3'h1;
                        if (s_r.bitcnt == 3'h7) begin
                            if (byte_in[7:1] == acr_pkg::DEV_ADDR) begin
                                s_nxt.st = acr_pkg::ST_ACK;
                                s_nxt.after = byte_in[0] ? acr_pkg::ST_RDATA : acr_pkg::ST_PTR;
                            end else begin
                                // Not ours: stay off the bus until the next start
                                s_nxt.st = acr_pkg::ST_IDLE;
                            end
                        end
                    end
                end
                acr_pkg::ST_PTR: begin
                    if (scl_rise) begin
                        s_nxt.shreg = byte_in;
                        s_nxt.bitcnt = s_r.bitcnt + 3'h1;
                        if (s_r.bitcnt == 3'h7) begin
                            s_nxt.ptr = byte_in;
                            s_nxt.st = acr_pkg::ST_ACK;
                            s_nxt.after = acr_pkg::ST_WDATA;
                        end
                    end
                end
                acr_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        s_nxt.shreg = byte_in;
                        s_nxt.bitcnt = s_r.bitcnt + 3'h1;
                        if (s_r.bitcnt == 3'h7) begin
                            case (s_r.ptr)
                                acr_pkg::OFS_INPUT_SETUP: begin
                                    // Reserved bit 1 is dropped on write
                                    s_nxt.regs.input_setup =
                                        byte_in & acr_pkg::WMASK_INPUT_SETUP;
                                end
                                acr_pkg::OFS_GAIN_SETTING: begin
                                    s_nxt.regs.gain_setting = byte_in;
                                end
                                acr_pkg::OFS_VOLUME_SETTING: begin
                                    s_nxt.regs.volume_setting = byte_in;
                                end
                                acr_pkg::OFS_GAIN_TRIM: begin
                                    s_nxt.regs.gain_trim =
                                        byte_in & acr_pkg::WMASK_GAIN_TRIM;
                                end
                                default: begin
                                    s_nxt.regs = s_r.regs;
                                end
                            endcase
                            // Auto-increment lets one frame fill the whole bank
                            s_nxt.ptr = s_r.ptr + 8'h01;
                            s_nxt.st = acr_pkg::ST_ACK;
                            s_nxt.after = acr_pkg::ST_WDATA;
                        end
                    end
                end
                acr_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (!s_r.ack_on) begin
                            s_nxt.sda_oe = 1'b1;
                            s_nxt.ack_on = 1'b1;
                        end else begin
                            s_nxt.ack_on = 1'b0;
                            s_nxt.bitcnt = 3'h0;
                            s_nxt.st = s_r.after;
                            if (s_r.after == acr_pkg::ST_RDATA) begin
                                s_nxt.shreg = rd_data;
                                s_nxt.sda_oe = ~rd_data[7];
                                s_nxt.ptr = s_r.ptr + 8'h01;
                            end else begin
                                s_nxt.sda_oe = 1'b0;
                            end
                        end
                    end
                end
                acr_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        s_nxt.bitcnt = s_r.bitcnt + 3'h1;
                        if (s_r.bitcnt == 3'h7) begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = acr_pkg::ST_RACK;
                        end else begin
                            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                            s_nxt.sda_oe = ~s_r.shreg[6];
                        end
                    end
                end
                acr_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        // Not-acknowledge ends the read burst
                        s_nxt.st = sda_in ? acr_pkg::ST_IDLE : acr_pkg::ST_RNEXT;
                    end
                end
                acr_pkg::ST_RNEXT: begin
                    if (scl_fall) begin
                        s_nxt.shreg = rd_data;
                        s_nxt.sda_oe = ~rd_data[7];
                        s_nxt.ptr = s_r.ptr + 8'h01;
                        s_nxt.bitcnt = 3'h0;
                        s_nxt.st = acr_pkg::ST_RDATA;
                    end
                end
                default: begin
                    s_nxt.st = acr_pkg::ST_IDLE;
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r.st <= acr_pkg::ST_IDLE;
            s_r.after <= acr_pkg::ST_IDLE;
            s_r.bitcnt <= 3'h0;
            s_r.shreg <= 8'h00;
            s_r.ptr <= 8'h00;
            s_r.ack_on <= 1'b0;
            s_r.scl_prev <= 1'b1;
            s_r.sda_prev <= 1'b1;
            s_r.sda_oe <= 1'b0;
            s_r.sda_o <= 1'b0;
            s_r.regs.input_setup <= acr_pkg::RST_INPUT_SETUP;
            s_r.regs.gain_setting <= acr_pkg::RST_GAIN_SETTING;
            s_r.regs.volume_setting <= acr_pkg::RST_VOLUME_SETTING;
            s_r.regs.gain_trim <= acr_pkg::RST_GAIN_TRIM;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Open drain: the pin is only ever pulled low
    assign sda_out = s_r.sda_o;
    assign sda_oe = s_r.sda_oe;

    acr_field_decode u_decode (
        .clock(clock),
        .rst(rst),
        .regs(s_r.regs),
        .cfg(cfg)
    );

endmodule // acr_channel_regs

// ### logic/acr_field_decode.sv
// Registered decoder from raw channel-two registers to per-function settings
`timescale 1ns/1ps
module acr_field_decode (
    input wire logic clock,
    input wire logic rst,
    input wire acr_pkg::acr_regs_s regs,
    output acr_pkg::acr_cfg_s cfg
);

    function automatic acr_pkg::acr_cfg_s decode(input acr_pkg::acr_regs_s r);
        acr_pkg::acr_cfg_s c;
        logic [1:0] src;
        logic [1:0] imp;
        logic [6:0] code;
        logic [6:0] mag;
        c = '0;
        src = r.input_setup[acr_pkg::SRC_HI:acr_pkg::SRC_LO];
        imp = r.input_setup[acr_pkg::IMP_HI:acr_pkg::IMP_LO];
        code = r.gain_setting[acr_pkg::GAIN_HI:acr_pkg::GAIN_LO];
        c.line_input = r.input_setup[acr_pkg::BIT_INPUT_KIND];
        c.src_differential = (src == acr_pkg::SRC_DIFFERENTIAL);
        c.src_single_ended = (src == acr_pkg::SRC_SINGLE_ENDED);
        c.src_pulse_mic = (src == acr_pkg::SRC_PULSE_MIC);
        // Coupling means nothing to the pulse-density path
        c.dc_coupled = r.input_setup[acr_pkg::BIT_COUPLING]
            & (c.src_differential | c.src_single_ended);
        c.imp_2k5 = (imp == acr_pkg::IMP_2K5);
        c.imp_10k = (imp == acr_pkg::IMP_10K);
        c.imp_20k = (imp == acr_pkg::IMP_20K);
        c.dynamic_processing_enable = r.input_setup[acr_pkg::BIT_PROCESSING];
        if (r.gain_setting[acr_pkg::BIT_POLARITY]) begin
            // Negative side clamps at the supported floor
            mag = (code > acr_pkg::GAIN_NEG_LIMIT) ? acr_pkg::GAIN_NEG_LIMIT : code;
            c.gain_half_db = 8'h00 - {1'b0, mag};
        end else begin
            c.gain_half_db = {1'b0, code};
        end
        c.volume_mute = (r.volume_setting == acr_pkg::VOL_MUTE);
        c.volume_half_db = {1'b0, r.volume_setting} - acr_pkg::VOL_UNITY;
        c.trim_tenth_db = {1'b0, r.gain_trim[acr_pkg::TRIM_HI:acr_pkg::TRIM_LO]}
            - acr_pkg::TRIM_ZERO;
        return c;
    endfunction

    localparam acr_pkg::acr_regs_s RST_REGS = '{
        input_setup: acr_pkg::RST_INPUT_SETUP,
        gain_setting: acr_pkg::RST_GAIN_SETTING,
        volume_setting: acr_pkg::RST_VOLUME_SETTING,
        gain_trim: acr_pkg::RST_GAIN_TRIM
    };
    localparam acr_pkg::acr_cfg_s RST_CFG = decode(RST_REGS);

    acr_pkg::acr_cfg_s cfg_r;
    acr_pkg::acr_cfg_s cfg_nxt;

    always_comb begin
        cfg_nxt = decode(regs);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_r <= RST_CFG;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    assign cfg = cfg_r;

endmodule // acr_field_decode

// ### logic/acr_pkg.sv
// Shared constants and types for the channel-two configuration register bank
package acr_pkg;

    // Control port device address; value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h4C;

    // Register offsets on the control port
    localparam logic [7:0] OFS_INPUT_SETUP = 8'h41;
    localparam logic [7:0] OFS_GAIN_SETTING = 8'h42;
    localparam logic [7:0] OFS_VOLUME_SETTING = 8'h43;
    localparam logic [7:0] OFS_GAIN_TRIM = 8'h44;

    // Reset values
    localparam logic [7:0] RST_INPUT_SETUP = 8'h00;
    localparam logic [7:0] RST_GAIN_SETTING = 8'h00;
    localparam logic [7:0] RST_VOLUME_SETTING = 8'hC9;
    localparam logic [7:0] RST_GAIN_TRIM = 8'h80;

    // Writable bits; the rest are reserved and read zero
    localparam logic [7:0] WMASK_INPUT_SETUP = 8'hFD;
    localparam logic [7:0] WMASK_GAIN_TRIM = 8'hF0;

    // Field positions
    localparam int BIT_INPUT_KIND = 7;
    localparam int SRC_HI = 6;
    localparam int SRC_LO = 5;
    localparam int BIT_COUPLING = 4;
    localparam int IMP_HI = 3;
    localparam int IMP_LO = 2;
    localparam int BIT_PROCESSING = 0;
    localparam int GAIN_HI = 7;
    localparam int GAIN_LO = 1;
    localparam int BIT_POLARITY = 0;
    localparam int TRIM_HI = 7;
    localparam int TRIM_LO = 4;

    // Field encodings
    localparam logic [1:0] SRC_DIFFERENTIAL = 2'h0;
    localparam logic [1:0] SRC_SINGLE_ENDED = 2'h1;
    localparam logic [1:0] SRC_PULSE_MIC = 2'h2;
    localparam logic [1:0] IMP_2K5 = 2'h0;
    localparam logic [1:0] IMP_10K = 2'h1;
    localparam logic [1:0] IMP_20K = 2'h2;

    // Gain arithmetic, all in the field's own step
    localparam logic [6:0] GAIN_NEG_LIMIT = 7'h16;
    localparam logic [7:0] VOL_MUTE = 8'h00;
    localparam logic [8:0] VOL_UNITY = 9'h0C9;
    localparam logic [4:0] TRIM_ZERO = 5'h08;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RACK,
        ST_RNEXT
    } acr_ctl_e;

    typedef struct packed {
        logic [7:0] input_setup;
        logic [7:0] gain_setting;
        logic [7:0] volume_setting;
        logic [7:0] gain_trim;
    } acr_regs_s;

    // Decoded settings; signed fields are two's complement
    typedef struct packed {
        logic line_input;
        logic src_differential;
        logic src_single_ended;
        logic src_pulse_mic;
        logic dc_coupled;
        logic imp_2k5;
        logic imp_10k;
        logic imp_20k;
        logic dynamic_processing_enable;
        logic [7:0] gain_half_db;
        logic volume_mute;
        logic [8:0] volume_half_db;
        logic [4:0] trim_tenth_db;
    } acr_cfg_s;

    typedef struct packed {
        acr_ctl_e st;
        acr_ctl_e after;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic ack_on;
        logic scl_prev;
        logic sda_prev;
        logic sda_oe;
        logic sda_o;
        acr_regs_s regs;
    } acr_ctl_s;

endpackage

// ### testbench/acr_channel_regs_props.sv
// Checker for the channel-two register bank control port and decoded settings
`timescale 1ns/1ps
module acr_channel_regs_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire acr_pkg::acr_cfg_s cfg
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    src_one_hot_a: assert property ($countones({cfg.src_differential, cfg.src_single_ended,
        cfg.src_pulse_mic}) <= 1) else $error("source select not one-hot");
    imp_one_hot_a: assert property ($countones({cfg.imp_2k5, cfg.imp_10k,
        cfg.imp_20k}) <= 1) else $error("impedance select not one-hot");
    coupling_analog_a: assert property (cfg.dc_coupled |->
        (cfg.src_differential || cfg.src_single_ended)) else $error("dc coupling on non-analog");
    neg_gain_floor_a: assert property (cfg.gain_half_db[7] |->
        $signed(cfg.gain_half_db) >= -22) else $error("negative gain below floor");
    volume_span_a: assert property (!cfg.volume_mute |->
        ($signed(cfg.volume_half_db) >= -200 && $signed(cfg.volume_half_db) <= 54))
        else $error("volume outside span");
    trim_span_a: assert property ($signed(cfg.trim_tenth_db) >= -8 &&
        $signed(cfg.trim_tenth_db) <= 7) else $error("trim outside span");
    reset_defaults_a: assert property ($fell(rst) |-> cfg.volume_half_db == 9'h000 &&
        !cfg.volume_mute && cfg.trim_tenth_db == 5'h00 && cfg.src_differential && cfg.imp_2k5)
        else $error("settings not at reset values");
    open_drain_a: assert property (sda_out == 1'b0) else $error("data pin driven high");
    oe_low_phase_a: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data pull started while clock high");
    oe_hold_a: assert property (scl_in && $past(scl_in) && $stable(sda_in) |->
        $stable(sda_oe)) else $error("data pull changed while clock high");

    cover property ($rose(sda_oe));
    cover property (cfg.src_pulse_mic);
    cover property (cfg.volume_mute);
    cover property (cfg.gain_half_db[7]);
endmodule // acr_channel_regs_props

bind acr_channel_regs acr_channel_regs_props u_props (.clock(clock), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg));

// ### testbench/tb_top.sv
// Self-checking bench for the channel-two configuration register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_top;
    typedef struct packed {logic [7:0] ofs; logic [7:0] wd; logic [9:0] ex;} acr_row_s;
    logic clock;
    logic rst;
    logic scl_in;
    logic sda_m;
    logic sda_out;
    logic sda_oe;
    logic sda_in;
    acr_pkg::acr_cfg_s cfg;
    int n_fail;
    int checks;
    logic [7:0] rd;
    logic ak;
    logic [8:0] ex9;
    logic [8:0] got9;
    logic [9:0] got;
    logic [7:0] rst_v[4] = '{8'h00, 8'h00, 8'hC9, 8'h80};
    // Reserved bits only ever written as zero; read-back shows they stay zero
    acr_row_s rows[8] = '{'{8'h41, 8'hFD, 10'h0FD},
        '{8'h41, 8'h08, 10'h008}, '{8'h42, 8'hA9, 10'h0A9}, '{8'h43, 8'h00, 10'h000},
        '{8'h44, 8'hF0, 10'h0F0}, '{8'h44, 8'h70, 10'h070},
        '{8'h43, 8'hFF, 10'h0FF}, '{8'h50, 8'h55, 10'h000}};
    // Gain codes stay within 0..84; negative ones only follow a 10k setting
    acr_row_s dec[10] = '{'{8'h42, 8'hA8, 10'h054}, '{8'h42, 8'h3D, 10'h0EA},
        '{8'h42, 8'h15, 10'h0F6}, '{8'h43, 8'h00, 10'h200}, '{8'h43, 8'h01, 10'h138},
        '{8'h43, 8'hFF, 10'h036}, '{8'h43, 8'hC9, 10'h000}, '{8'h44, 8'h00, 10'h018},
        '{8'h44, 8'hF0, 10'h007}, '{8'h44, 8'h80, 10'h000}};

    // Open-drain wire with pull-up
    assign sda_in = sda_m & ~(sda_oe & ~sda_out);

    acr_channel_regs dut (.clock(clock), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic hc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wbit(input logic b);
        sda_m = b;
        hc(2);
        scl_in = 1'b1;
        hc(3);
        scl_in = 1'b0;
        hc(2);
    endtask
    task automatic rbit(output logic b);
        sda_m = 1'b1;
        hc(2);
        scl_in = 1'b1;
        hc(2);
        b = sda_in;
        hc(1);
        scl_in = 1'b0;
        hc(2);
    endtask
    task automatic wbyte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) wbit(d[i]);
        rbit(ak);
    endtask
    task automatic start;
        sda_m = 1'b1;
        hc(2);
        scl_in = 1'b1;
        hc(3);
        sda_m = 1'b0;
        hc(3);
        scl_in = 1'b0;
        hc(2);
    endtask
    task automatic stop;
        sda_m = 1'b0;
        hc(2);
        scl_in = 1'b1;
        hc(3);
        sda_m = 1'b1;
        hc(3);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        start();
        wbyte({acr_pkg::DEV_ADDR, 1'b0});
        wbyte(ofs);
        wbyte(d);
        `CHK("ack", 1'b0, ak)
        stop();
    endtask
    task automatic rdr(input logic [7:0] ofs);
        start();
        wbyte({acr_pkg::DEV_ADDR, 1'b0});
        wbyte(ofs);
        start();
        wbyte({acr_pkg::DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) rbit(rd[i]);
        wbit(1'b1);
        stop();
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_fail++;
        $display("watchdog expired");
        results();
    end

    initial begin
        rst = 1'b1;
        scl_in = 1'b1;
        sda_m = 1'b1;
        n_fail = 0;
        checks = 0;
        hc(6);
        rst = 1'b0;
        hc(2);
        for (int i = 0; i < 4; i++) begin
            rdr(8'h41 + 8'(i));
            `CHK("reset reg", rst_v[i], rd)
        end
        `CHK("reset cfg", 2'b11, {cfg.src_differential, cfg.imp_2k5})
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].ofs, rows[i].wd);
            rdr(rows[i].ofs);
            `CHK("readback", rows[i].ex[7:0], rd)
        end
        $display("test readback done");
        for (int s = 0; s < 4; s++) begin
            // Pin functions for the chosen source are set up outside this block
            // Last pass leaves the 10k impedance in place for the negative gain rows
            wr(8'h41, {s[0], 2'(s), 1'b1, 2'(s + 2), 1'b0, ~s[0]});
            hc(2);
            ex9 = {s[0], s == 0, s == 1, s == 2, s < 2, s == 2, s == 3, s == 0, ~s[0]};
            got9 = {cfg.line_input, cfg.src_differential, cfg.src_single_ended,
                cfg.src_pulse_mic, cfg.dc_coupled, cfg.imp_2k5, cfg.imp_10k, cfg.imp_20k,
                cfg.dynamic_processing_enable};
            `CHK("setup", ex9, got9)
        end
        $display("test input setup done");
        foreach (dec[i]) begin
            wr(dec[i].ofs, dec[i].wd);
            hc(2);
            // Volume value is meaningless while muted, so it is masked
            got = dec[i].ofs == 8'h42 ? {2'b00, cfg.gain_half_db} :
                dec[i].ofs == 8'h44 ? {5'h00, cfg.trim_tenth_db} :
                {cfg.volume_mute, cfg.volume_mute ? 9'h000 : cfg.volume_half_db};
            `CHK("decode", dec[i].ex, got)
        end
        $display("test decode done");
        start();
        wbyte({acr_pkg::DEV_ADDR ^ 7'h01, 1'b0});
        `CHK("nack", 1'b1, ak)
        stop();
        wr(8'h43, 8'h10);
        rst = 1'b1;
        hc(1);
        rst = 1'b0;
        hc(2);
        rdr(8'h43);
        `CHK("mid reset", 8'hC9, rd)
        $display("test address and reset done");
        results();
    end
endmodule // tb_top
